// >>> ieg_pkg.sv
// package: register map, field positions, reset values and timing constants
package ieg_pkg;
   localparam logic [7:0] OFS_CFG_ONE       = 8'h30;
   localparam logic [7:0] OFS_SOURCE_ONE    = 8'h31;
   localparam logic [7:0] OFS_THRESHOLD_ONE = 8'h32;
   localparam logic [7:0] OFS_DURATION_ONE  = 8'h33;
   localparam logic [7:0] OFS_CFG_TWO       = 8'h34;
   localparam logic [7:0] OFS_SOURCE_TWO    = 8'h35;
   localparam logic [7:0] OFS_THRESHOLD_TWO = 8'h36;
   localparam logic [7:0] OFS_DURATION_TWO  = 8'h37;
   localparam logic [7:0] OFS_PIN_CONTROL   = 8'h22;
   localparam logic [7:0] OFS_FILTER_SELECT = 8'h21;

   // configuration register fields
   localparam int CFG_COMBINE_SELECT = 7;
   localparam int CFG_LATCH_REQUEST  = 6;
   localparam int CFG_Z_HIGH_ENABLE  = 5;
   localparam int CFG_Z_LOW_ENABLE   = 4;
   localparam int CFG_Y_HIGH_ENABLE  = 3;
   localparam int CFG_Y_LOW_ENABLE   = 2;
   localparam int CFG_X_HIGH_ENABLE  = 1;
   localparam int CFG_X_LOW_ENABLE   = 0;
   // source register fields
   localparam int SRC_EVENT_ACTIVE   = 6;
   // threshold register fields
   localparam int THS_COUNTER_MODE   = 7;
   localparam int THS_VALUE_WIDTH    = 7;
   // pin control register fields
   localparam int PIN_IRQ_POLARITY   = 7;
   localparam int PIN_TWO_ROUTE_LSB  = 3;
   localparam int PIN_ONE_ROUTE_LSB  = 0;
   // filter select fields, one bit per generator
   localparam int FLT_GEN_ONE        = 2;
   localparam int FLT_GEN_TWO        = 3;

   localparam logic [7:0] RST_REG    = 8'h00;

   // pin route codes
   localparam logic [2:0] ROUTE_OFF   = 3'h0;
   localparam logic [2:0] ROUTE_ONE   = 3'h1;
   localparam logic [2:0] ROUTE_TWO   = 3'h2;
   localparam logic [2:0] ROUTE_BOTH  = 3'h3;
   localparam logic [2:0] ROUTE_READY = 3'h4;

   // duration step per sample rate (us)
   localparam int STEP_US_400HZ = 2500;
   localparam int STEP_US_100HZ = 10000;
   localparam int DURATION_WIDTH = 8;

   typedef enum logic [2:0] {
      GEN_IDLE    = 3'b001,
      GEN_COUNT   = 3'b010,
      GEN_FROZEN  = 3'b100
   } ieg_gen_state_t;
endpackage

// >>> ieg_regfile.sv
// memory of eight byte registers with a registered read port
`timescale 1ns/100ps
module ieg_regfile
   import ieg_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   input  wire logic       i_we,
   input  wire logic [2:0] i_waddr,
   input  wire logic [7:0] i_wdata,
   input  wire logic [2:0] i_raddr,
   output logic [7:0]      o_rdata,
   output logic [63:0]     o_flat
);
   logic [7:0] mem_ff [8];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_word
         always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
               mem_ff[g] <= RST_REG;
            end else if (i_we && i_waddr == 3'(g)) begin
               mem_ff[g] <= i_wdata;
            end
         end
         assign o_flat[g*8 +: 8] = mem_ff[g];
      end
   endgenerate

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= RST_REG;
      end else begin
         o_rdata <= mem_ff[i_raddr];
      end
   end
endmodule

// >>> ieg_generator.sv
// one inertial event generator: comparators, combiner, duration counter, source
`timescale 1ns/100ps
module ieg_generator
   import ieg_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   input  wire logic       i_sample,
   input  wire logic [7:0] i_x,
   input  wire logic [7:0] i_y,
   input  wire logic [7:0] i_z,
   input  wire logic [7:0] i_cfg,
   input  wire logic [7:0] i_ths,
   input  wire logic [7:0] i_dur,
   input  wire logic       i_src_read,
   output logic [7:0]      o_source,
   output logic            o_irq
);
   function automatic logic [7:0] magnitude(input logic [7:0] s);
      logic [7:0] m;
      m = s[7] ? 8'(~s + 8'h01) : s;
      return m;
   endfunction

   logic [7:0]     mag [3];
   logic [5:0]     live_flags;
   logic [5:0]     enables;
   logic           combined;
   logic           qualified;
   logic [7:0]     count_ff;
   logic [7:0]     nxt_count;
   logic [6:0]     source_ff;
   ieg_gen_state_t state_ff;
   ieg_gen_state_t nxt_state;
   logic           latch_on;

   assign mag[0] = magnitude(i_x);
   assign mag[1] = magnitude(i_y);
   assign mag[2] = magnitude(i_z);
   assign latch_on = i_cfg[CFG_LATCH_REQUEST];

   // flags order: x_low, x_high, y_low, y_high, z_low, z_high
   genvar a;
   generate
      for (a = 0; a < 3; a++) begin : g_axis
         assign live_flags[2*a+1] = mag[a] >= {1'b0, i_ths[THS_VALUE_WIDTH-1:0]}; // RULE4 RULE6
         assign live_flags[2*a]   = mag[a] <  {1'b0, i_ths[THS_VALUE_WIDTH-1:0]}; // RULE5 RULE7
      end
   endgenerate

   assign enables = i_cfg[5:0];

   // and-mode with nothing enabled never fires
   always_comb begin
      if (i_cfg[CFG_COMBINE_SELECT]) begin
         combined = (enables != 6'h00) && ((live_flags & enables) == enables); // RULE1
      end else begin
         combined = |(live_flags & enables); // RULE1
      end
   end

   assign qualified = combined && (count_ff >= i_dur); // RULE24 RULE15 RULE16

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         // a zero duration qualifies straight from idle, so latching must start here too
         GEN_IDLE:   if (latch_on && qualified) nxt_state = GEN_FROZEN; // RULE2
                     else if (combined) nxt_state = GEN_COUNT;
         GEN_COUNT:  if (latch_on && qualified) nxt_state = GEN_FROZEN; // RULE17
                     else if (!combined && count_ff == 8'h00) nxt_state = GEN_IDLE;
         GEN_FROZEN: if (i_src_read) nxt_state = GEN_IDLE; // RULE11
         default:    nxt_state = GEN_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_ff <= GEN_IDLE;
      end else if (i_src_read && state_ff == GEN_FROZEN) begin
         state_ff <= GEN_IDLE; // RULE11
      end else if (i_sample) begin
         // a read alone never freezes: the source would hold nothing captured
         state_ff <= nxt_state;
      end
   end

   // one step per output sample; a frozen counter keeps its value
   always_comb begin
      nxt_count = count_ff;
      if (state_ff == GEN_FROZEN) begin
         nxt_count = count_ff; // RULE17
      end else if (combined) begin
         if (count_ff != 8'hff) nxt_count = 8'(count_ff + 8'h01); // RULE24
      end else if (i_ths[THS_COUNTER_MODE]) begin
         if (count_ff != 8'h00) nxt_count = 8'(count_ff - 8'h01); // RULE14
      end else begin
         nxt_count = 8'h00; // RULE13
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_ff <= 8'h00;
      end else if (i_src_read && state_ff == GEN_FROZEN) begin
         count_ff <= 8'h00;
      end else if (i_sample) begin
         count_ff <= nxt_count;
      end
   end

   // outside the frozen state a new sample wins over a read in the same cycle so no event is lost
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         source_ff <= 7'h00;
      end else if (i_sample && state_ff != GEN_FROZEN) begin
         source_ff <= {qualified, live_flags & enables}; // RULE8 RULE10 RULE2
      end else if (i_src_read) begin
         source_ff <= 7'h00; // RULE3 RULE11
      end
   end

   assign o_source = {1'b0, source_ff};
   assign o_irq    = source_ff[SRC_EVENT_ACTIVE]; // RULE9
endmodule

// >>> ieg_top.sv
// two inertial event interrupt generators behind the serial register port
// Notes on behaviour
// RULE1 - combine select 0 ors enabled axis events, 1 ands them
// RULE2 - latch request holds request and flags; otherwise they follow live state
// RULE3 - latched request clears only on read of its own source register
// RULE4 - axis high enable makes event when magnitude is at or above threshold
// RULE5 - axis low enable makes event when magnitude is below threshold
// RULE6 - threshold is seven bits unsigned; high means magnitude at or above
// RULE7 - low means magnitude strictly below the threshold
// RULE8 - source holds six axis flags and event active flag
// RULE9 - generator interrupt comes from its event active flag
// RULE10 - source shows current events, or frozen triggering events when latched
// RULE11 - reading source clears it and interrupt, and reopens latched updating
// RULE12 - source register is read only; writes are ignored
// RULE13 - counter mode 0 resets duration counter when event inactive
// RULE14 - counter mode 1 decrements duration counter when event inactive
// RULE15 - eight bit duration, 2.5 ms steps at 400 Hz, up to 637.5 ms
// RULE16 - at 100 Hz steps are 10 ms, up to 2.55 s
// RULE17 - duration counter stops once event occurred with latch request set
// RULE18 - two generators with own registers, identical and independent
// RULE19 - either generator result routable to either interrupt pin
// RULE20 - route codes: off, gen one, gen two, both ored, data ready
// RULE21 - polarity 0 means active high pins, 1 active low
// RULE22 - per generator select of filtered or unfiltered input, default unfiltered
// RULE23 - second generator registers at 35h, 36h, 37h behave like first
// RULE24 - counter advances per sample; event active when count reaches duration
`timescale 1ns/100ps
module ieg_top
   import ieg_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   // register port as decoded by the serial interface
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output logic [7:0]      o_reg_rdata,
   output logic            o_reg_rvalid,
   // sample stream, one pulse per output sample
   input  wire logic       i_sample,
   input  wire logic [7:0] i_raw_x,
   input  wire logic [7:0] i_raw_y,
   input  wire logic [7:0] i_raw_z,
   input  wire logic [7:0] i_filt_x,
   input  wire logic [7:0] i_filt_y,
   input  wire logic [7:0] i_filt_z,
   input  wire logic       i_data_ready,
   output logic            o_irq_pin_one,
   output logic            o_irq_pin_two
);
   logic [63:0] regs;
   logic [7:0]  rf_rdata;
   logic [7:0]  source [2];
   logic        inertial_irq [2];
   logic        src_read [2];
   logic        rf_we;
   logic [2:0]  rf_waddr;
   logic [7:0]  pin_control_ff;
   logic [7:0]  filter_select_ff;
   logic        rd_pending_ff;
   logic [7:0]  rd_addr_ff;
   logic [7:0]  src_snap_ff;
   logic        pin_one_level;
   logic        pin_two_level;

   function automatic logic in_block(input logic [7:0] addr);
      return addr[7:3] == OFS_CFG_ONE[7:3];
   endfunction

   function automatic logic route_level(input logic [2:0] code, input logic g1,
                                        input logic g2, input logic rdy);
      logic lvl;
      lvl = 1'b0;
      unique case (code)
         ROUTE_OFF:   lvl = 1'b0;
         ROUTE_ONE:   lvl = g1;
         ROUTE_TWO:   lvl = g2;
         ROUTE_BOTH:  lvl = g1 | g2;
         ROUTE_READY: lvl = rdy;
         default:     lvl = 1'b0;
      endcase
      return lvl;
   endfunction

   // source offsets are dropped from the store so writes there do nothing
   assign rf_we = i_reg_wr && in_block(i_reg_addr) &&
                  i_reg_addr != OFS_SOURCE_ONE && i_reg_addr != OFS_SOURCE_TWO; // RULE12
   assign rf_waddr = i_reg_addr[2:0];

   ieg_regfile u_regfile (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_we     (rf_we),
      .i_waddr  (rf_waddr),
      .i_wdata  (i_reg_wdata),
      .i_raddr  (i_reg_addr[2:0]),
      .o_rdata  (rf_rdata),
      .o_flat   (regs)
   );

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_control_ff <= RST_REG;
      end else if (i_reg_wr && i_reg_addr == OFS_PIN_CONTROL) begin
         pin_control_ff <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         filter_select_ff <= RST_REG;
      end else if (i_reg_wr && i_reg_addr == OFS_FILTER_SELECT) begin
         filter_select_ff <= i_reg_wdata;
      end
   end

   assign src_read[0] = i_reg_rd && i_reg_addr == OFS_SOURCE_ONE; // RULE3
   assign src_read[1] = i_reg_rd && i_reg_addr == OFS_SOURCE_TWO; // RULE23

   // the source value is caught before the read clears it
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         src_snap_ff <= 8'h00;
      end else if (src_read[0]) begin
         src_snap_ff <= source[0];
      end else if (src_read[1]) begin
         src_snap_ff <= source[1];
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_pending_ff <= 1'b0;
         rd_addr_ff    <= 8'h00;
      end else begin
         rd_pending_ff <= i_reg_rd;
         rd_addr_ff    <= i_reg_addr;
      end
   end

   assign o_reg_rvalid = rd_pending_ff;

   always_comb begin
      if (rd_addr_ff == OFS_SOURCE_ONE || rd_addr_ff == OFS_SOURCE_TWO) begin
         o_reg_rdata = src_snap_ff;
      end else if (in_block(rd_addr_ff)) begin
         o_reg_rdata = rf_rdata;
      end else if (rd_addr_ff == OFS_PIN_CONTROL) begin
         o_reg_rdata = pin_control_ff;
      end else if (rd_addr_ff == OFS_FILTER_SELECT) begin
         o_reg_rdata = filter_select_ff;
      end else begin
         o_reg_rdata = 8'h00;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_gen
         logic       use_filt;
         logic [7:0] sx;
         logic [7:0] sy;
         logic [7:0] sz;
         assign use_filt = filter_select_ff[g == 0 ? FLT_GEN_ONE : FLT_GEN_TWO]; // RULE22
         assign sx = use_filt ? i_filt_x : i_raw_x; // RULE22
         assign sy = use_filt ? i_filt_y : i_raw_y;
         assign sz = use_filt ? i_filt_z : i_raw_z;

         // each generator owns one block of four registers
         ieg_generator u_gen ( // RULE18 RULE23
            .i_mclk     (i_mclk),
            .i_resetn   (i_resetn),
            .i_sample   (i_sample),
            .i_x        (sx),
            .i_y        (sy),
            .i_z        (sz),
            .i_cfg      (regs[(g*4)*8 +: 8]),
            .i_ths      (regs[(g*4+2)*8 +: 8]),
            .i_dur      (regs[(g*4+3)*8 +: 8]),
            .i_src_read (src_read[g]),
            .o_source   (source[g]),
            .o_irq      (inertial_irq[g])
         );
      end
   endgenerate

   assign pin_one_level = route_level(pin_control_ff[PIN_ONE_ROUTE_LSB +: 3],
                                      inertial_irq[0], inertial_irq[1], i_data_ready); // RULE19 RULE20
   assign pin_two_level = route_level(pin_control_ff[PIN_TWO_ROUTE_LSB +: 3],
                                      inertial_irq[0], inertial_irq[1], i_data_ready); // RULE19 RULE20

   // pins are combinational from registered state and i_data_ready; polarity applies after routing
   assign o_irq_pin_one = pin_one_level ^ pin_control_ff[PIN_IRQ_POLARITY]; // RULE21
   assign o_irq_pin_two = pin_two_level ^ pin_control_ff[PIN_IRQ_POLARITY]; // RULE21
endmodule

// >>> ieg_host_model.sv
// host side model: byte writes and reads on the register port
`timescale 1ns/100ps
module ieg_host_model (
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata
);
   initial begin
      o_wr = 1'h0;
      o_rd = 1'h0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // strobes last one cycle; bus lines are scrambled between accesses
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #1;
      o_wr = 1'h1;
      o_addr = a;
      o_wdata = d;
      @(posedge i_mclk);
      #1;
      o_wr = 1'h0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      #1;
      o_rd = 1'h1;
      o_addr = a;
      @(posedge i_mclk);
      #1;
      o_rd = 1'h0;
      o_addr = ~a;
      d = i_rvalid ? i_rdata : 8'hxx;
   endtask
endmodule

// >>> ieg_checker.sv
// checker of register port answers and pin levels at the top ports
`timescale 1ns/100ps
module ieg_checker
   import ieg_pkg::*;
(
   input wire logic       i_mclk,
   input wire logic       i_resetn,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_reg_rvalid,
   input wire logic       i_sample,
   input wire logic       i_data_ready,
   input wire logic       o_irq_pin_one,
   input wire logic       o_irq_pin_two
);
   logic [7:0] pin_ctl_ff;
   logic       src_rd;
   logic       mapped;
   assign src_rd = i_reg_rd && i_reg_addr == OFS_SOURCE_ONE && !i_sample;
   assign mapped = i_reg_addr inside {[8'h30:8'h37], OFS_PIN_CONTROL, OFS_FILTER_SELECT};
   // shadow of pin control so the pins can be judged from the ports alone
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_ctl_ff <= RST_REG;
      end else if (i_reg_wr && i_reg_addr == OFS_PIN_CONTROL) begin
         pin_ctl_ff <= i_reg_wdata;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   read_answer_a : assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read got no answer");
   no_stray_valid_a : assert property (!i_reg_rd |=> !o_reg_rvalid)
      else $error("answer without read");
   pin_off_a : assert property (pin_ctl_ff[2:0] == ROUTE_OFF |-> o_irq_pin_one == pin_ctl_ff[7])
      else $error("pin one not inactive for route off");
   spare_code_a : assert property (pin_ctl_ff[2:0] > ROUTE_READY |-> o_irq_pin_one == pin_ctl_ff[7])
      else $error("pin one not inactive for spare route");
   ready_route_a : assert property (pin_ctl_ff[5:3] == ROUTE_READY |->
      o_irq_pin_two == (i_data_ready ^ pin_ctl_ff[7])) else $error("pin two not data ready");
   ctl_readback_a : assert property (i_reg_rd && i_reg_addr == OFS_PIN_CONTROL |=>
      o_reg_rdata == pin_ctl_ff) else $error("pin control readback wrong");
   src_top_zero_a : assert property (src_rd |=> !o_reg_rdata[7])
      else $error("source bit seven set");
   read_clears_a : assert property (src_rd ##1 !i_sample ##1 src_rd |=> o_reg_rdata == 8'h00)
      else $error("source not cleared by read");
   unmapped_zero_a : assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   quiet_pins_a : assert property (!i_sample && !i_reg_wr && !i_reg_rd ##1 $stable(i_data_ready)
      |-> $stable(o_irq_pin_one) && $stable(o_irq_pin_two)) else $error("pin moved without cause");
endmodule
bind ieg_top ieg_checker u_ieg_checker (.i_mclk(i_mclk), .i_resetn(i_resetn),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_sample(i_sample), .i_data_ready(i_data_ready), .o_irq_pin_one(o_irq_pin_one),
   .o_irq_pin_two(o_irq_pin_two));

// >>> ieg_top_bench.sv
// self-checking bench for the two inertial event generators
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module ieg_top_bench;
   import ieg_pkg::*;
   typedef struct packed {logic gen; logic [7:0] cfg, ths, x, y, z, src;} ieg_row_t;
   logic       i_mclk, i_resetn, wr, rd, rvalid, smp_s, dr, p1, p2;
   logic [7:0] addr, wdata, rdata, rx, ry, rz, filt, base, d;
   logic [2:0] code;
   logic       exp;
   int         fails = 0;
   int         n_checks = 0;
   ieg_row_t   rows [9] = '{
      '{1'h0, 8'h02, 8'h10, 8'h10, 8'h00, 8'h00, 8'h42}, '{1'h0, 8'h02, 8'h10, 8'h0f, 8'h00, 8'h00, 8'h00},
      '{1'h0, 8'h02, 8'h10, 8'hf0, 8'h00, 8'h00, 8'h42}, '{1'h0, 8'h02, 8'h10, 8'h80, 8'h00, 8'h00, 8'h42},
      '{1'h1, 8'h95, 8'h10, 8'h05, 8'hfb, 8'h00, 8'h55}, '{1'h1, 8'h95, 8'h10, 8'h05, 8'hfb, 8'h20, 8'h05},
      '{1'h1, 8'h28, 8'h7f, 8'h00, 8'h7e, 8'h81, 8'h60}, '{1'h0, 8'h01, 8'h90, 8'h0f, 8'h00, 8'h00, 8'h41},
      '{1'h1, 8'h01, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00}};
   ieg_top u_ieg_top (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_sample(smp_s), .i_raw_x(rx), .i_raw_y(ry), .i_raw_z(rz), .i_filt_x(filt),
      .i_filt_y(filt), .i_filt_z(filt), .i_data_ready(dr), .o_irq_pin_one(p1),
      .o_irq_pin_two(p2));
   ieg_host_model u_ieg_host_model (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid),
      .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   initial begin
      i_mclk = 1'h0;
      forever #10 i_mclk = ~i_mclk;
   end
   // sample values are only valid with the strobe, so they are scrambled after it
   task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
      @(posedge i_mclk);
      #1;
      {smp_s, rx, ry, rz} = {1'h1, x, y, z};
      @(posedge i_mclk);
      #1;
      {smp_s, rx, ry, rz} = {1'h0, ~x, ~y, ~z};
   endtask
   task automatic step(input logic [7:0] x, input logic e);
      smp(x, 8'h00, 8'h00);
      `CHK("pin one", e, p1)
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      fails++;
      wrap_up();
   end
   initial begin
      {i_resetn, smp_s, dr, rx, ry, rz, filt} = '0;
      repeat (16) @(posedge i_mclk);
      #1;
      i_resetn = 1'h1;
      u_ieg_host_model.wr(OFS_PIN_CONTROL, 8'h11);
      for (int i = 0; i < 9; i++) begin
         base = rows[i].gen ? OFS_CFG_TWO : OFS_CFG_ONE;
         u_ieg_host_model.wr(base ^ 8'h04, 8'h00);
         u_ieg_host_model.wr(base, rows[i].cfg);
         u_ieg_host_model.wr(base + 8'h02, rows[i].ths);
         u_ieg_host_model.wr(base + 8'h03, 8'h00);
         smp(rows[i].x, rows[i].y, rows[i].z);
         `CHK("pin one", rows[i].src[SRC_EVENT_ACTIVE] & ~rows[i].gen, p1)
         `CHK("pin two", rows[i].src[SRC_EVENT_ACTIVE] & rows[i].gen, p2)
         u_ieg_host_model.rd(base + 8'h01, d);
         `CHK("source", rows[i].src, d)
      end
      u_ieg_host_model.wr(OFS_CFG_TWO, 8'h00);
      u_ieg_host_model.wr(OFS_CFG_ONE, 8'h02);
      u_ieg_host_model.wr(OFS_THRESHOLD_ONE, 8'h10);
      u_ieg_host_model.wr(OFS_DURATION_ONE, 8'h02);
      step(8'h00, 1'h0);
      step(8'h20, 1'h0);
      step(8'h20, 1'h0);
      step(8'h00, 1'h0);
      step(8'h20, 1'h0);
      step(8'h20, 1'h0);
      step(8'h20, 1'h1);
      step(8'h00, 1'h0);
      u_ieg_host_model.wr(OFS_THRESHOLD_ONE, 8'h90);
      step(8'h20, 1'h0);
      step(8'h20, 1'h0);
      step(8'h00, 1'h0);
      step(8'h20, 1'h0);
      step(8'h20, 1'h1);
      u_ieg_host_model.wr(OFS_DURATION_ONE, 8'h00);
      u_ieg_host_model.wr(OFS_CFG_ONE, 8'h42);
      step(8'h20, 1'h1);
      step(8'h00, 1'h1);
      u_ieg_host_model.rd(OFS_SOURCE_TWO, d);
      `CHK("pin one", 1'h1, p1)
      u_ieg_host_model.rd(OFS_SOURCE_ONE, d);
      `CHK("frozen source", 8'h42, d)
      `CHK("pin one", 1'h0, p1)
      u_ieg_host_model.wr(OFS_SOURCE_ONE, 8'hff);
      u_ieg_host_model.rd(OFS_SOURCE_ONE, d);
      `CHK("source", 8'h00, d)
      u_ieg_host_model.rd(8'h40, d);
      `CHK("unmapped", 8'h00, d)
      step(8'h20, 1'h1);
      step(8'h00, 1'h1);
      dr = 1'h1;
      for (int k = 0; k < 16; k++) begin
         code = k[2:0];
         u_ieg_host_model.wr(OFS_PIN_CONTROL, {k[3], 1'h0, code, code});
         exp = (code == ROUTE_ONE || code == ROUTE_BOTH || code == ROUTE_READY) ^ k[3];
         `CHK("pin two route", exp, p2)
         `CHK("pin one route", exp, p1)
      end
      u_ieg_host_model.wr(OFS_PIN_CONTROL, 8'h01);
      u_ieg_host_model.rd(OFS_PIN_CONTROL, d);
      `CHK("pin control", 8'h01, d)
      u_ieg_host_model.wr(OFS_CFG_ONE, 8'h02);
      u_ieg_host_model.rd(OFS_SOURCE_ONE, d);
      `CHK("latched source", 8'h42, d)
      u_ieg_host_model.rd(OFS_SOURCE_ONE, d);
      `CHK("source after read", 8'h00, d)
      filt = 8'h20;
      u_ieg_host_model.wr(OFS_FILTER_SELECT, 8'h04);
      step(8'h00, 1'h1);
      u_ieg_host_model.wr(OFS_FILTER_SELECT, 8'h00);
      step(8'h00, 1'h0);
      step(8'h20, 1'h1);
      i_resetn = 1'h0;
      repeat (2) @(posedge i_mclk);
      #1;
      i_resetn = 1'h1;
      `CHK("pin one after reset", 1'h0, p1)
      u_ieg_host_model.rd(OFS_FILTER_SELECT, d);
      `CHK("filter select reset", 8'h00, d)
      wrap_up();
   end
endmodule
